// ===== common/table_pkg.sv
// Shared constants and types for the table engine and its issuer.
// Assumes one clock for both ends and a 16-bit variable memory.
package table_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int DEPTH = 256;
  localparam int LEN_W = 8;
  localparam int CNT_W = 12;
  localparam int WORD_BITS_LOG2 = 4;
  localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
  localparam logic [LEN_W-1:0] LEN_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
  localparam logic [ADDR_W-1:0] ONE_ADDR = 8'h01;
  localparam logic [LEN_W-1:0] ONE_LEN = 8'h01;
  localparam logic [CNT_W-1:0] ONE_CNT = 12'h001;
  localparam logic [DATA_W-1:0] ONE_WORD = 16'h0001;
  localparam logic [3:0] ZERO_NIB = 4'h0;

  // Table operations carried over the link.
  typedef enum logic [2:0] {
    PUSH_TO_TOP_OP,
    TABLE_SHIFT_LEFT_OP,
    TABLE_SHIFT_RIGHT_OP,
    AND_COPY_OP,
    OR_COPY_OP
  } op_e;
endpackage : table_pkg

// ===== common/table_link.sv
// Link between the program scan issuer and the table engine.
// Assumes both ends share clk; no tristate signals are used.
`timescale 1ns/1ps
interface table_link (
  input wire logic clk
);
  logic req;
  table_pkg::op_e op;
  logic [table_pkg::LEN_W-1:0] tlen;
  logic [table_pkg::ADDR_W-1:0] base;
  logic [table_pkg::DATA_W-1:0] operand;
  logic [table_pkg::DATA_W-1:0] pattern;
  logic scan_end;
  logic mem_we;
  logic [table_pkg::ADDR_W-1:0] mem_addr;
  logic [table_pkg::DATA_W-1:0] mem_wdata;
  logic [table_pkg::DATA_W-1:0] mem_rdata;
  logic busy;
  logic done;
  logic table_full_flag;
  logic shift_overrange_flag;
  logic shifted_out_one_flag;

  // Engine end of the link.
  modport device_mp (
    input req, op, tlen, base, operand, pattern, scan_end,
    input mem_we, mem_addr, mem_wdata,
    output mem_rdata, busy, done,
    output table_full_flag, shift_overrange_flag, shifted_out_one_flag
  );

  // Issuer end of the link.
  modport issuer_mp (
    output req, op, tlen, base, operand, pattern, scan_end,
    output mem_we, mem_addr, mem_wdata,
    input mem_rdata, busy, done,
    input table_full_flag, shift_overrange_flag, shifted_out_one_flag
  );
endinterface : table_link

// ===== core/table_engine.sv
// Table engine: push-to-top, table shifts and masked table copies
// on a flip-flop variable memory.
// Assumes the issuer sends one request at a time while busy is low.
// Functional notes
// - Push inserts source at head, shifts entries down.
// - Push runs once per scan while enabled.
// - Issuer gives table length 0..FF first.
// - Start word is counter; entries follow it.
// - Pushed word read from operand address.
// - Counter zero or above length: no insert.
// - Executed push increments counter by one.
// - Issuer initialises counter; engine never presets.
// - Full flag when counter equals length.
// - Insertions allowed equal length minus counter.
// - Flags last until scan end or reuse.
// - Left shift moves table bits upward.
// - Right shift moves table bits downward.
// - Bits carry across words as one string.
// - Boundary bits discarded, zeros shifted in.
// - Shift count octal; sixteen bits per word.
// - Overrange flag when count exceeds table bits.
// - Out-one flag when last discarded bit set.
// - AND copy masks each word into destination.
// - OR copy merges each word into destination.
`timescale 1ns/1ps
module table_engine (
  input wire logic clk,
  input wire logic sys_rst,
  table_link.device_mp link,
  output logic engine_busy
);
  typedef enum logic [2:0] {
    IDLE, PUSH_CHK, PUSH_MOVE, PUSH_INS, PUSH_CNT, SHIFT_PASS, COPY, FINISH
  } state_e;

  state_e state_r, state_nxt;
  table_pkg::op_e op_r, op_nxt;
  logic [table_pkg::LEN_W-1:0] len_r, len_nxt;
  logic [table_pkg::ADDR_W-1:0] base_r, base_nxt;
  logic [table_pkg::DATA_W-1:0] opnd_r, opnd_nxt;
  logic [table_pkg::DATA_W-1:0] pat_r, pat_nxt;
  logic [table_pkg::DATA_W-1:0] word_r, word_nxt;
  logic [table_pkg::DATA_W-1:0] cnt_r, cnt_nxt;
  logic [table_pkg::LEN_W-1:0] idx_r, idx_nxt;
  logic [table_pkg::CNT_W-1:0] passes_r, passes_nxt;
  logic carry_r, carry_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic full_r, full_nxt;
  logic over_r, over_nxt;
  logic one_r, one_nxt;
  logic [table_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
  logic [table_pkg::DATA_W-1:0] mem_r [0:table_pkg::DEPTH-1];
  logic wr_en;
  logic [table_pkg::ADDR_W-1:0] wr_addr;
  logic [table_pkg::DATA_W-1:0] wr_data;
  logic [table_pkg::ADDR_W-1:0] cur_addr;
  logic [table_pkg::LEN_W-1:0] last_idx;
  logic [table_pkg::CNT_W-1:0] req_bits;
  logic [table_pkg::CNT_W-1:0] total_bits;
  logic [table_pkg::DATA_W-1:0] shifted;
  logic carry_out;

  // Address of the table word under work and index of the last entry.
  assign cur_addr = table_pkg::ADDR_W'(base_r + idx_r);
  assign last_idx = table_pkg::LEN_W'(len_r - table_pkg::ONE_LEN);
  // The shift count is four octal digits, one per nibble.
  assign req_bits = {link.operand[14:12], link.operand[10:8],
                     link.operand[6:4], link.operand[2:0]};
  assign total_bits = {link.tlen, table_pkg::ZERO_NIB};

  // One-bit shift of the current word, carrying between neighbours.
  always_comb begin
    if (op_r == table_pkg::TABLE_SHIFT_RIGHT_OP) begin
      shifted = {carry_r, mem_r[cur_addr][15:1]};
      carry_out = mem_r[cur_addr][0];
    end else begin
      shifted = {mem_r[cur_addr][14:0], carry_r};
      carry_out = mem_r[cur_addr][15];
    end
  end

  // Sequencer: one memory write per cycle at most.
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    len_nxt = len_r;
    base_nxt = base_r;
    opnd_nxt = opnd_r;
    pat_nxt = pat_r;
    word_nxt = word_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    passes_nxt = passes_r;
    carry_nxt = carry_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    rdata_nxt = mem_r[link.mem_addr];
    wr_en = 1'b0;
    wr_addr = cur_addr;
    wr_data = word_r;
    // Scan end clears the flags; a write later in this process wins.
    full_nxt = link.scan_end ? 1'b0 : full_r;
    over_nxt = link.scan_end ? 1'b0 : over_r;
    one_nxt = link.scan_end ? 1'b0 : one_r;
    unique case (state_r)
      IDLE: begin
        if (link.mem_we) begin
          wr_en = 1'b1;
          wr_addr = link.mem_addr;
          wr_data = link.mem_wdata;
        end
        if (link.req) begin
          op_nxt = link.op;
          len_nxt = link.tlen;
          base_nxt = link.base;
          opnd_nxt = link.operand;
          pat_nxt = link.pattern;
          busy_nxt = 1'b1;
          idx_nxt = table_pkg::LEN_RST;
          carry_nxt = 1'b0;
          unique case (link.op)
            table_pkg::PUSH_TO_TOP_OP: state_nxt = PUSH_CHK;
            table_pkg::TABLE_SHIFT_LEFT_OP, table_pkg::TABLE_SHIFT_RIGHT_OP: begin
              over_nxt = (req_bits > total_bits);
              one_nxt = 1'b0;
              passes_nxt = req_bits;
              if (link.op == table_pkg::TABLE_SHIFT_RIGHT_OP) begin
                idx_nxt = table_pkg::LEN_W'(link.tlen - table_pkg::ONE_LEN);
              end
              if (req_bits > total_bits || req_bits == table_pkg::CNT_RST) begin
                state_nxt = FINISH;
              end else begin
                state_nxt = SHIFT_PASS;
              end
            end
            table_pkg::AND_COPY_OP, table_pkg::OR_COPY_OP: begin
              state_nxt = (link.tlen == table_pkg::LEN_RST) ? FINISH : COPY;
            end
            // Unused operation codes end at once and leave memory untouched.
            default: begin
              state_nxt = FINISH;
            end
          endcase
        end
      end
      PUSH_CHK: begin
        cnt_nxt = mem_r[base_r];
        word_nxt = mem_r[opnd_r[table_pkg::ADDR_W-1:0]];
        if (mem_r[base_r] != table_pkg::WORD_RST &&
            mem_r[base_r] < {table_pkg::LEN_RST, len_r}) begin
          idx_nxt = len_r;
          state_nxt = PUSH_MOVE;
        end else begin
          full_nxt = (mem_r[base_r] == {table_pkg::LEN_RST, len_r});
          state_nxt = FINISH;
        end
      end
      PUSH_MOVE: begin
        // Walk from the tail so no entry is overwritten before it moves.
        if (idx_r > table_pkg::ONE_LEN) begin
          wr_en = 1'b1;
          wr_data = mem_r[table_pkg::ADDR_W'(cur_addr - table_pkg::ONE_ADDR)];
          idx_nxt = table_pkg::LEN_W'(idx_r - table_pkg::ONE_LEN);
        end else begin
          state_nxt = PUSH_INS;
        end
      end
      PUSH_INS: begin
        wr_en = 1'b1;
        wr_addr = table_pkg::ADDR_W'(base_r + table_pkg::ONE_ADDR);
        wr_data = word_r;
        state_nxt = PUSH_CNT;
      end
      PUSH_CNT: begin
        wr_en = 1'b1;
        wr_addr = base_r;
        wr_data = table_pkg::DATA_W'(cnt_r + table_pkg::ONE_WORD);
        full_nxt = (table_pkg::DATA_W'(cnt_r + table_pkg::ONE_WORD) ==
                    {table_pkg::LEN_RST, len_r});
        state_nxt = FINISH;
      end
      SHIFT_PASS: begin
        wr_en = 1'b1;
        wr_data = shifted;
        carry_nxt = carry_out;
        if ((op_r == table_pkg::TABLE_SHIFT_RIGHT_OP) ? (idx_r == table_pkg::LEN_RST)
            : (idx_r == last_idx)) begin
          // The carry out of the far end is discarded; zero enters next pass.
          carry_nxt = 1'b0;
          one_nxt = carry_out;
          passes_nxt = table_pkg::CNT_W'(passes_r - table_pkg::ONE_CNT);
          idx_nxt = (op_r == table_pkg::TABLE_SHIFT_RIGHT_OP) ? last_idx
                    : table_pkg::LEN_RST;
          if (passes_r == table_pkg::ONE_CNT) begin
            state_nxt = FINISH;
          end
        end else if (op_r == table_pkg::TABLE_SHIFT_RIGHT_OP) begin
          idx_nxt = table_pkg::LEN_W'(idx_r - table_pkg::ONE_LEN);
        end else begin
          idx_nxt = table_pkg::LEN_W'(idx_r + table_pkg::ONE_LEN);
        end
      end
      COPY: begin
        wr_en = 1'b1;
        wr_addr = table_pkg::ADDR_W'(opnd_r[table_pkg::ADDR_W-1:0] + idx_r);
        if (op_r == table_pkg::AND_COPY_OP) begin
          wr_data = mem_r[cur_addr] & pat_r;
        end else begin
          wr_data = mem_r[cur_addr] | pat_r;
        end
        idx_nxt = table_pkg::LEN_W'(idx_r + table_pkg::ONE_LEN);
        if (idx_r == last_idx) begin
          state_nxt = FINISH;
        end
      end
      FINISH: begin
        done_nxt = 1'b1;
        busy_nxt = 1'b0;
        state_nxt = IDLE;
      end
    endcase
  end

  // Registers of the sequencer.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= IDLE;
      op_r <= table_pkg::PUSH_TO_TOP_OP;
      len_r <= table_pkg::LEN_RST;
      base_r <= table_pkg::ADDR_RST;
      opnd_r <= table_pkg::WORD_RST;
      pat_r <= table_pkg::WORD_RST;
      word_r <= table_pkg::WORD_RST;
      cnt_r <= table_pkg::WORD_RST;
      idx_r <= table_pkg::LEN_RST;
      passes_r <= table_pkg::CNT_RST;
      carry_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      full_r <= 1'b0;
      over_r <= 1'b0;
      one_r <= 1'b0;
      rdata_r <= table_pkg::WORD_RST;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      len_r <= len_nxt;
      base_r <= base_nxt;
      opnd_r <= opnd_nxt;
      pat_r <= pat_nxt;
      word_r <= word_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      passes_r <= passes_nxt;
      carry_r <= carry_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      full_r <= full_nxt;
      over_r <= over_nxt;
      one_r <= one_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Variable memory, one flip-flop word per entry.
  for (genvar i = 0; i < table_pkg::DEPTH; i++) begin : g_mem
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        mem_r[i] <= table_pkg::WORD_RST;
      end else if (wr_en && wr_addr == table_pkg::ADDR_W'(i)) begin
        mem_r[i] <= wr_data;
      end
    end
  end

  // Outputs come straight from registers.
  assign link.busy = busy_r;
  assign link.done = done_r;
  assign link.mem_rdata = rdata_r;
  assign link.table_full_flag = full_r;
  assign link.shift_overrange_flag = over_r;
  assign link.shifted_out_one_flag = one_r;
  assign engine_busy = busy_r;
endmodule : table_engine

// ===== core/table_issuer.sv
// Scan-side issuer: forwards table commands, at most one per scan.
// Assumes user-side inputs are synchronous to clk.
`timescale 1ns/1ps
module table_issuer (
  input wire logic clk,
  input wire logic sys_rst,
  table_link.issuer_mp link,
  input wire logic cmd_valid,
  input wire table_pkg::op_e cmd_op,
  input wire logic [table_pkg::LEN_W-1:0] cmd_len,
  input wire logic [table_pkg::ADDR_W-1:0] cmd_base,
  input wire logic [table_pkg::DATA_W-1:0] cmd_operand,
  input wire logic [table_pkg::DATA_W-1:0] cmd_pattern,
  output logic cmd_ready,
  input wire logic scan_tick,
  input wire logic mem_we_in,
  input wire logic [table_pkg::ADDR_W-1:0] mem_addr_in,
  input wire logic [table_pkg::DATA_W-1:0] mem_wdata_in,
  output logic [table_pkg::DATA_W-1:0] mem_rdata,
  output logic op_done,
  output logic table_full_flag,
  output logic shift_overrange_flag,
  output logic shifted_out_one_flag
);
  typedef enum logic {ISSUE_IDLE, ISSUE_WAIT} istate_e;

  istate_e st_r, st_nxt;
  logic issued_r, issued_nxt;
  logic ready_r, ready_nxt;
  logic req_r, req_nxt;
  table_pkg::op_e op_r, op_nxt;
  logic [table_pkg::LEN_W-1:0] len_r, len_nxt;
  logic [table_pkg::ADDR_W-1:0] base_r, base_nxt;
  logic [table_pkg::DATA_W-1:0] opnd_r, opnd_nxt;
  logic [table_pkg::DATA_W-1:0] pat_r, pat_nxt;
  logic accept;

  assign accept = cmd_valid && ready_r;

  // Command hand-off; the engine sees one request pulse per scan at most.
  always_comb begin
    st_nxt = st_r;
    issued_nxt = issued_r;
    req_nxt = 1'b0;
    op_nxt = op_r;
    len_nxt = len_r;
    base_nxt = base_r;
    opnd_nxt = opnd_r;
    pat_nxt = pat_r;
    unique case (st_r)
      ISSUE_IDLE: begin
        if (accept) begin
          req_nxt = 1'b1;
          op_nxt = cmd_op;
          len_nxt = cmd_len;
          base_nxt = cmd_base;
          opnd_nxt = cmd_operand;
          pat_nxt = cmd_pattern;
          issued_nxt = 1'b1;
          st_nxt = ISSUE_WAIT;
        end
      end
      ISSUE_WAIT: begin
        if (link.done) begin
          st_nxt = ISSUE_IDLE;
        end
      end
    endcase
    // A new scan re-opens the slot for the next operation.
    if (scan_tick) begin
      issued_nxt = 1'b0;
    end
    ready_nxt = (st_nxt == ISSUE_IDLE) && !issued_nxt && !req_nxt;
  end

  // Registers of the issuer and the forwarded link signals.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= ISSUE_IDLE;
      issued_r <= 1'b0;
      ready_r <= 1'b0;
      req_r <= 1'b0;
      op_r <= table_pkg::PUSH_TO_TOP_OP;
      len_r <= table_pkg::LEN_RST;
      base_r <= table_pkg::ADDR_RST;
      opnd_r <= table_pkg::WORD_RST;
      pat_r <= table_pkg::WORD_RST;
      link.scan_end <= 1'b0;
      link.mem_we <= 1'b0;
      link.mem_addr <= table_pkg::ADDR_RST;
      link.mem_wdata <= table_pkg::WORD_RST;
      mem_rdata <= table_pkg::WORD_RST;
      op_done <= 1'b0;
      table_full_flag <= 1'b0;
      shift_overrange_flag <= 1'b0;
      shifted_out_one_flag <= 1'b0;
    end else begin
      st_r <= st_nxt;
      issued_r <= issued_nxt;
      ready_r <= ready_nxt;
      req_r <= req_nxt;
      op_r <= op_nxt;
      len_r <= len_nxt;
      base_r <= base_nxt;
      opnd_r <= opnd_nxt;
      pat_r <= pat_nxt;
      link.scan_end <= scan_tick;
      link.mem_we <= mem_we_in;
      link.mem_addr <= mem_addr_in;
      link.mem_wdata <= mem_wdata_in;
      mem_rdata <= link.mem_rdata;
      op_done <= link.done;
      table_full_flag <= link.table_full_flag;
      shift_overrange_flag <= link.shift_overrange_flag;
      shifted_out_one_flag <= link.shifted_out_one_flag;
    end
  end

  assign cmd_ready = ready_r;
  assign link.req = req_r;
  assign link.op = op_r;
  assign link.tlen = len_r;
  assign link.base = base_r;
  assign link.operand = opnd_r;
  assign link.pattern = pat_r;
endmodule : table_issuer

// ===== test/table_link_sva.sv
// Checker for the table link: request, answer and status flag timing.
// Assumes one clock and a synchronous active-high reset on the link.
`timescale 1ns/1ps
module table_link_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req,
  input wire table_pkg::op_e op,
  input wire logic [table_pkg::LEN_W-1:0] tlen,
  input wire logic [table_pkg::DATA_W-1:0] operand,
  input wire logic scan_end,
  input wire logic busy,
  input wire logic done,
  input wire logic table_full_flag,
  input wire logic shift_overrange_flag,
  input wire logic shifted_out_one_flag
);
  logic [11:0] shift_cnt;
  logic is_shift;
  logic [2:0] flags;

  // The shift count packs the low three bits of each octal digit nibble.
  assign shift_cnt = {operand[14:12], operand[10:8], operand[6:4], operand[2:0]};
  assign is_shift = (op == table_pkg::TABLE_SHIFT_LEFT_OP) || (op == table_pkg::TABLE_SHIFT_RIGHT_OP);
  assign flags = {table_full_flag, shift_overrange_flag, shifted_out_one_flag};

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_req_sets_busy: assert property (req && !busy |=> busy)
    else $error("busy did not follow a request");
  a_done_one_pulse: assert property (done |=> !done)
    else $error("done lasted more than one cycle");
  a_done_when_idle: assert property (done |-> !busy)
    else $error("done seen while busy");
  a_push_answer_bound: assert property (req && op == table_pkg::PUSH_TO_TOP_OP |-> ##[2:270] done)
    else $error("push did not finish in time");
  a_copy_two_words: assert property (req && tlen == 8'h02 && (op == table_pkg::AND_COPY_OP || op == table_pkg::OR_COPY_OP) |-> ##4 done)
    else $error("two word copy took the wrong time");
  a_shift_over_range: assert property (req && is_shift && shift_cnt > {tlen, 4'h0} |-> ##2 (done && shift_overrange_flag))
    else $error("overrange shift not flagged");
  a_shift_zero_count: assert property (req && is_shift && shift_cnt == 12'h000 |-> ##2 (done && !shift_overrange_flag && !shifted_out_one_flag))
    else $error("zero shift count misbehaved");
  a_flags_hold_idle: assert property (!busy && !scan_end && !req |=> $stable(flags))
    else $error("flags changed while idle");
  a_flags_clear_scan: assert property (scan_end && !busy && !req |=> flags == 3'h0)
    else $error("flags not cleared at scan end");

  // Main scenarios that the bench is expected to reach.
  cover property (req && op == table_pkg::PUSH_TO_TOP_OP);
  cover property (done && table_full_flag);
  cover property (done && shifted_out_one_flag);
endmodule : table_link_sva

// ===== test/test_table_push_shift_logic_unit.sv
// Testbench: engine and issuer joined by the link, driven from the issuer's user side.
// Assumes a 100 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
module test_table_push_shift_logic_unit;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  table_pkg::op_e cmd_op = table_pkg::PUSH_TO_TOP_OP;
  logic [7:0] cmd_len = 8'h00;
  logic [7:0] cmd_base = 8'h00;
  logic [15:0] cmd_operand = 16'h0000;
  logic [15:0] cmd_pattern = 16'h0000;
  logic scan_tick = 1'b0;
  logic mem_we_in = 1'b0;
  logic [7:0] mem_addr_in = 8'h00;
  logic [15:0] mem_wdata_in = 16'h0000;
  logic cmd_ready, op_done, full_f, ovr_f, out1_f, eng_busy;
  logic [15:0] mem_rdata;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;

  table_link u_table_link (.clk(clk));
  table_engine u_table_engine (.clk(clk), .sys_rst(sys_rst), .link(u_table_link.device_mp),
    .engine_busy(eng_busy));
  table_issuer u_table_issuer (.clk(clk), .sys_rst(sys_rst), .link(u_table_link.issuer_mp),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_len(cmd_len), .cmd_base(cmd_base),
    .cmd_operand(cmd_operand), .cmd_pattern(cmd_pattern), .cmd_ready(cmd_ready),
    .scan_tick(scan_tick), .mem_we_in(mem_we_in), .mem_addr_in(mem_addr_in),
    .mem_wdata_in(mem_wdata_in), .mem_rdata(mem_rdata), .op_done(op_done),
    .table_full_flag(full_f), .shift_overrange_flag(ovr_f), .shifted_out_one_flag(out1_f));
  table_link_sva u_table_link_sva (.clk(clk), .sys_rst(sys_rst), .req(u_table_link.req),
    .op(u_table_link.op), .tlen(u_table_link.tlen), .operand(u_table_link.operand),
    .scan_end(u_table_link.scan_end), .busy(u_table_link.busy), .done(u_table_link.done),
    .table_full_flag(u_table_link.table_full_flag),
    .shift_overrange_flag(u_table_link.shift_overrange_flag),
    .shifted_out_one_flag(u_table_link.shifted_out_one_flag));

  // Clock and the hang guard.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    mem_we_in <= 1'b1;
    mem_addr_in <= a;
    mem_wdata_in <= d;
    @(posedge clk);
    mem_we_in <= 1'b0;
  endtask : wr

  // Reads a word once the read pipeline has settled and compares it.
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    mem_addr_in <= a;
    repeat (5) @(posedge clk);
    @(negedge clk);
    check($sformatf("word %h", a), mem_rdata, exp);
  endtask : rdc

  task automatic tab2(input logic [7:0] a, input logic [31:0] v);
    rdc(a, v[15:0]);
    rdc(a + 8'h01, v[31:16]);
  endtask : tab2

  task automatic flags(input logic [2:0] exp);
    check("flags", {13'h0000, full_f, ovr_f, out1_f}, {13'h0000, exp});
  endtask : flags

  task automatic tick();
    @(posedge clk);
    scan_tick <= 1'b1;
    @(posedge clk);
    scan_tick <= 1'b0;
    repeat (4) @(negedge clk);
  endtask : tick

  // Opens a new scan, issues one command and waits for its completion.
  task automatic run_op(input table_pkg::op_e o, input logic [7:0] l, input logic [7:0] b,
                        input logic [15:0] opd, input logic [15:0] pat);
    int k;
    tick();
    k = 0;
    while (cmd_ready !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
    cmd_op <= o;
    cmd_len <= l;
    cmd_base <= b;
    cmd_operand <= opd;
    cmd_pattern <= pat;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    k = 0;
    while (op_done !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
    check("op_done", {15'h0000, op_done}, 16'h0001);
    check("engine_busy", {15'h0000, eng_busy}, 16'h0000);
    check("cmd_ready", {15'h0000, cmd_ready}, 16'h0000);
    repeat (3) @(negedge clk);
  endtask : run_op

  // Pushes into a four word table until full, then refused pushes.
  task automatic push_scenario();
    int i;
    logic [15:0] tab [4];
    tab = '{16'h0600, 16'h0500, 16'h00A1, 16'h00A2};
    wr(8'h10, 16'h0002);
    for (i = 0; i < 4; i++) begin
      wr(8'h11 + 8'(i), 16'h00A1 + 16'(i));
    end
    wr(8'h30, 16'h0500);
    run_op(table_pkg::PUSH_TO_TOP_OP, 8'h04, 8'h10, 16'h0030, 16'h0000);
    flags(3'b000);
    wr(8'h30, 16'h0600);
    run_op(table_pkg::PUSH_TO_TOP_OP, 8'h04, 8'h10, 16'h0030, 16'h0000);
    flags(3'b100);
    rdc(8'h10, 16'h0004);
    for (i = 0; i < 4; i++) begin
      rdc(8'h11 + 8'(i), tab[i]);
    end
    run_op(table_pkg::PUSH_TO_TOP_OP, 8'h04, 8'h10, 16'h0030, 16'h0000);
    rdc(8'h10, 16'h0004);
    rdc(8'h11, 16'h0600);
    tick();
    flags(3'b000);
    wr(8'h10, 16'h0000);
    run_op(table_pkg::PUSH_TO_TOP_OP, 8'h04, 8'h10, 16'h0030, 16'h0000);
    rdc(8'h10, 16'h0000);
    rdc(8'h11, 16'h0600);
  endtask : push_scenario

  // Shifts a two word table left, out of range, right by octal 21 and by zero.
  task automatic shift_scenario();
    logic [31:0] v;
    v = 32'h8000_8001;
    wr(8'h40, v[15:0]);
    wr(8'h41, v[31:16]);
    tab2(8'h40, v);
    run_op(table_pkg::TABLE_SHIFT_LEFT_OP, 8'h02, 8'h40, 16'h0001, 16'h0000);
    flags({2'b00, v[31]});
    v = v << 1;
    tab2(8'h40, v);
    run_op(table_pkg::TABLE_SHIFT_LEFT_OP, 8'h02, 8'h40, 16'h0041, 16'h0000);
    flags(3'b010);
    tab2(8'h40, v);
    run_op(table_pkg::TABLE_SHIFT_RIGHT_OP, 8'h02, 8'h40, 16'h0021, 16'h0000);
    flags({2'b00, v[16]});
    v = v >> 17;
    tab2(8'h40, v);
    run_op(table_pkg::TABLE_SHIFT_LEFT_OP, 8'h02, 8'h40, 16'h0000, 16'h0000);
    flags(3'b000);
  endtask : shift_scenario

  // Copies a two word table through the AND and the OR mask.
  task automatic copy_scenario();
    wr(8'h50, 16'h1234);
    wr(8'h51, 16'h5678);
    run_op(table_pkg::AND_COPY_OP, 8'h02, 8'h50, 16'h0060, 16'h6666);
    rdc(8'h60, 16'h1234 & 16'h6666);
    rdc(8'h61, 16'h5678 & 16'h6666);
    run_op(table_pkg::OR_COPY_OP, 8'h02, 8'h50, 16'h0070, 16'h8888);
    rdc(8'h70, 16'h1234 | 16'h8888);
    rdc(8'h71, 16'h5678 | 16'h8888);
  endtask : copy_scenario

  // Reset, then the scenarios in turn.
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    push_scenario();
    shift_scenario();
    copy_scenario();
    wrap_up();
  end
endmodule : test_table_push_shift_logic_unit
